//--- design/scp_pkg.sv
/*
 package for the serial configuration memory reader: sizes, reset values,
 state encodings and timing constants.
 assumes nothing of its surroundings.
*/
package scp_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 8;
   localparam int unsigned ACCESS_DELAY_NS  = 8;
   localparam int unsigned ACCESS_CYCLES    = (ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DEF_LIMIT        = 1024;
   localparam int unsigned DEF_ADDR_W       = 11;
   localparam int unsigned BUF_DEPTH        = 2;
   localparam logic        GATE_POL_HIGH    = 1'b1;
   localparam logic        CASCADE_RST_VAL  = 1'b1;
   localparam logic        DATA_OE_RST_VAL  = 1'b0;

   typedef enum logic [1:0] {
      SCP_CLEAR,
      SCP_READING,
      SCP_DONE,
      SCP_HELD
   } scp_state_t;
endpackage

//--- design/scp_sync.sv
/*
 two flip-flop synchroniser for one level.
 assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module scp_sync
  #(parameter logic RST_VAL = 1'b0)
  (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output var  logic sync_out
  );

   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;

   always_comb
   begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- design/scp_buf2.sv
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock; the drain may stall freely.
*/
`timescale 1ns/10ps
`default_nettype none
module scp_buf2
  #(parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = scp_pkg::BUF_DEPTH)
  (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
  );

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [PW-1:0]    rd_ff;
   logic [PW-1:0]    wr_ff;
   logic [PW:0]      cnt_ff;
   logic [PW-1:0]    nxt_rd;
   logic [PW-1:0]    nxt_wr;
   logic [PW:0]      nxt_cnt;
   logic             push;
   logic             pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_comb
   begin
      push    = in_valid && (cnt_ff != (PW+1)'(DEPTH));
      pop     = out_ready && (cnt_ff != '0);
      nxt_mem = mem_ff;
      nxt_rd  = rd_ff;
      nxt_wr  = wr_ff;
      nxt_cnt = cnt_ff;
      if (flush)
      begin
         nxt_rd  = '0;
         nxt_wr  = '0;
         nxt_cnt = '0;
      end
      else
      begin
         if (push)
         begin
            nxt_mem[wr_ff] = in_data;
            nxt_wr         = bump(wr_ff);
         end
         if (pop)
            nxt_rd = bump(rd_ff);
         if (push && !pop)
            nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
         else if (pop && !push)
            nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_ff[i] <= '0;
         rd_ff  <= '0;
         wr_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         mem_ff <= nxt_mem;
         rd_ff  <= nxt_rd;
         wr_ff  <= nxt_wr;
         cnt_ff <= nxt_cnt;
      end
   end

   assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];
endmodule
`default_nettype wire

//--- design/scp_reader.sv
/*
 read side of a one-time-programmable bit-serial configuration memory.
 a counter walks the stored bits on each rising config_clock while the
 select and the gate are both active; the bit goes out on a three-state
 data pin and a cascade enable hands over to the next memory.
 assumes: config_clock, select_n and the gate come from outside and are
 sampled on clk, which must run well above config_clock; the loader
 keeps its own timing (clock count, release of select, shared clock).
 bits are fetched ahead into a two-entry buffer, so a slow fetch never stalls the loader.
*/
// Notes on behaviour
// R1: the address advances by one on each rising config_clock while select and gate are active.
// R2: the data pin floats whenever select or gate is inactive or the last bit is passed, and is driven otherwise.
// R3: while the gate is at its clear level the address is held at zero and data floats.
// R4: the clear level of the gate is a stored option, high or low.
// R5: select high freezes the address, floats data and enters standby.
// R6: cascade enable goes low only when select and gate are active and the last bit is passed.
// R7: after the last bit the cascade enable follows select while the gate stays active.
// R8: once the gate is inactive the cascade enable stays high until the address is cleared.
// R9: each new bit appears a short delay after the clock edge that chose it.
// R10: the loader makes the clock and gives exactly as many pulses as it needs.
// R11: after loading the loader releases select so the memory stops.
// R12: in slave loading memory and logic device share one outside clock.
// R13: in a chain each cascade enable drives the next select; clocks and data are shared.
// R14: on the clock edge after the last bit the cascade enable goes low and data is released.
// R15: in standby data floats whatever the gate level.
// R16: limit and counter width are parameters and the counter does not wrap past the limit.
`timescale 1ns/10ps
`default_nettype none
module scp_reader
  #(parameter int unsigned LAST_ADDRESS_LIMIT = scp_pkg::DEF_LIMIT,
    parameter int unsigned ADDR_W             = scp_pkg::DEF_ADDR_W,
    parameter logic        GATE_CLEAR_HIGH    = scp_pkg::GATE_POL_HIGH)
  (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        config_clock,
   input  wire logic        select_n,
   input  wire logic        clear_gate,
   output var  logic        data_out,
   output var  logic        data_oe,
   output var  logic        cascade_enable_out_n,
   output var  logic        standby,
   output var  logic        rom_rd_en,
   output var  logic [ADDR_W-1:0] rom_addr,
   input  wire logic        rom_bit,
   output var  logic        read_done
  );

   logic sel_n_s;
   logic gate_s;
   logic config_clock_s;
   logic config_clock_d_ff;
   logic nxt_config_clock_d;
   logic sel_act;
   logic gate_act;
   logic both_act;
   logic rise;

   logic [ADDR_W:0]  addr_ff;
   logic [ADDR_W:0]  nxt_addr;
   logic             past_ff;
   logic             nxt_past;
   logic             hold_ff;
   logic             nxt_hold;
   scp_pkg::scp_state_t state_ff;
   scp_pkg::scp_state_t nxt_state;

   logic data_ff;
   logic oe_ff;
   logic ceo_ff;
   logic sb_ff;
   logic nxt_data;
   logic nxt_oe;
   logic nxt_ceo;
   logic nxt_sb;

   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_bit;
   logic buf_flush;
   logic fetch;

   // true on the last stored address
   function automatic logic is_last(input logic [ADDR_W:0] a);
      is_last = (a == (ADDR_W+1)'(LAST_ADDRESS_LIMIT - 1));
   endfunction

   function automatic logic is_clear(input logic lvl);
      is_clear = (lvl == GATE_CLEAR_HIGH);
   endfunction

   scp_sync #(.RST_VAL(1'b0)) u_sync_clk
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (config_clock),
      .sync_out (config_clock_s)
   );

   scp_sync #(.RST_VAL(1'b1)) u_sync_sel
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (select_n),
      .sync_out (sel_n_s)
   );

   scp_sync #(.RST_VAL(GATE_CLEAR_HIGH)) u_sync_gate
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in (clear_gate),
      .sync_out (gate_s)
   );

   // clear level picked by the stored polarity option
   // edges come from the synchronised copy, never from the raw pin
   always_comb
   begin
      nxt_config_clock_d = config_clock_s;
      sel_act    = !sel_n_s;
      gate_act   = !is_clear(gate_s); // R4
      both_act   = sel_act && gate_act;
      rise       = config_clock_s && !config_clock_d_ff;
   end

   // address fetch path: rom read feeds the two-entry buffer
   assign fetch     = both_act && !past_ff && buf_in_ready;
   assign buf_flush = !gate_act;

   scp_buf2 #(.WIDTH(1), .DEPTH(scp_pkg::BUF_DEPTH)) u_buf
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .flush     (buf_flush),
      .in_valid  (rom_rd_en),
      .in_ready  (buf_in_ready),
      .in_data   (rom_bit),
      .out_valid (buf_out_valid),
      .out_ready (rise && both_act),
      .out_data  (buf_out_bit)
   );

   // counter and cascade state
   always_comb
   begin
      nxt_addr  = addr_ff;
      nxt_past  = past_ff;
      nxt_hold  = hold_ff;
      nxt_state = state_ff;
      case (state_ff)
         scp_pkg::SCP_CLEAR:
         begin
            if (gate_act)
               nxt_state = scp_pkg::SCP_READING;
         end
         scp_pkg::SCP_READING:
         begin
            if (rise && both_act)
            begin
               if (is_last(addr_ff))
               begin
                  nxt_past  = 1'b1; // R14
                  nxt_state = scp_pkg::SCP_DONE;
               end
               else
                  nxt_addr = (ADDR_W+1)'(addr_ff + 1'b1); // R1
            end
         end
         scp_pkg::SCP_DONE:
         begin
            nxt_addr = addr_ff; // R16
         end
         scp_pkg::SCP_HELD:
         begin
            nxt_hold = 1'b1; // R8
         end
         default:
            nxt_state = scp_pkg::SCP_CLEAR;
      endcase
      if (!gate_act && past_ff)
      begin
         nxt_hold  = 1'b1; // R8
         nxt_state = scp_pkg::SCP_HELD;
      end
      if (is_clear(gate_s))
      begin
         nxt_addr  = '0; // R3
         nxt_past  = 1'b0;
         nxt_hold  = 1'b0;
         nxt_state = scp_pkg::SCP_CLEAR;
      end
   end

   // pin drivers
   always_comb
   begin
      nxt_sb   = sel_n_s; // R5
      // data is released on the edge at which the cascade enable drops
      nxt_oe   = both_act && !past_ff; // R2 R15 R14
      nxt_data = oe_ff ? data_ff : 1'b0;
      if (both_act && buf_out_valid && !past_ff)
         nxt_data = buf_out_bit; // R9
      if (hold_ff || !gate_act)
         nxt_ceo = 1'b1; // R8
      else if (past_ff)
         nxt_ceo = sel_n_s; // R6 R7
      else
         nxt_ceo = 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_clock_d_ff <= 1'b0;
         addr_ff   <= '0;
         past_ff   <= 1'b0;
         hold_ff   <= 1'b0;
         state_ff  <= scp_pkg::SCP_CLEAR;
         data_ff   <= 1'b0;
         oe_ff     <= scp_pkg::DATA_OE_RST_VAL;
         ceo_ff    <= scp_pkg::CASCADE_RST_VAL;
         sb_ff     <= 1'b1;
      end
      else
      begin
         config_clock_d_ff <= nxt_config_clock_d;
         addr_ff   <= nxt_addr;
         past_ff   <= nxt_past;
         hold_ff   <= nxt_hold;
         state_ff  <= nxt_state;
         data_ff   <= nxt_data;
         oe_ff     <= nxt_oe;
         ceo_ff    <= nxt_ceo;
         sb_ff     <= nxt_sb;
      end
   end

   // fetch handshake: an address moves on only when the buffer took its bit,
   // so a full buffer stalls the fetch instead of skipping an address
   logic [ADDR_W-1:0] pf_ff;
   logic [ADDR_W-1:0] nxt_pf;
   logic              rd_ff;
   logic              nxt_rd;
   logic              fdone_ff;
   logic              nxt_fdone;
   logic              taken;
   logic              pf_last;

   always_comb
   begin
      taken     = rd_ff && buf_in_ready;
      pf_last   = is_last({1'b0, pf_ff});
      nxt_pf    = pf_ff;
      nxt_rd    = rd_ff;
      nxt_fdone = fdone_ff;
      if (taken)
      begin
         if (pf_last)
            nxt_fdone = 1'b1; // R16
         else
            nxt_pf = ADDR_W'(pf_ff + 1'b1);
      end
      // a strobe that was not taken stays up on the same address
      if (!rd_ff || taken)
         nxt_rd = fetch && !fdone_ff && !(taken && pf_last);
      if (!gate_act)
      begin
         nxt_pf    = '0; // R3
         nxt_rd    = 1'b0;
         nxt_fdone = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pf_ff    <= '0;
         rd_ff    <= 1'b0;
         fdone_ff <= 1'b0;
      end
      else
      begin
         pf_ff    <= nxt_pf;
         rd_ff    <= nxt_rd;
         fdone_ff <= nxt_fdone;
      end
   end

   assign rom_rd_en            = rd_ff;
   assign rom_addr             = pf_ff;
   assign data_out             = data_ff;
   assign data_oe              = oe_ff;
   assign cascade_enable_out_n = ceo_ff;
   assign standby              = sb_ff;
   assign read_done            = past_ff;
endmodule
`default_nettype wire

//--- verification/scp_reader_props.sv
/*
 checker for the serial configuration memory reader.
 assumes it is bound onto scp_reader and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module scp_reader_props
  #(parameter int unsigned LAST_ADDRESS_LIMIT = 8,
    parameter int unsigned ADDR_W             = 4,
    parameter logic        GATE_CLEAR_HIGH    = 1'b1)
  (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              config_clock,
   input wire logic              select_n,
   input wire logic              clear_gate,
   input wire logic              data_out,
   input wire logic              data_oe,
   input wire logic              cascade_enable_out_n,
   input wire logic              standby,
   input wire logic              rom_rd_en,
   input wire logic [ADDR_W-1:0] rom_addr,
   input wire logic              rom_bit,
   input wire logic              read_done
  );
   logic       clr;
   logic       config_clock_q_ff;
   logic [2:0] quiet_ff;
   logic [2:0] nxt_quiet;
   assign clr = (clear_gate == GATE_CLEAR_HIGH);
   // cycles since config_clock last moved, saturating
   always_comb
   begin
      nxt_quiet = quiet_ff;
      if (config_clock != config_clock_q_ff)
         nxt_quiet = 3'h0;
      else if (quiet_ff != 3'h7)
         nxt_quiet = quiet_ff + 3'h1;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         quiet_ff <= 3'h0;
         config_clock_q_ff <= 1'b0;
      end
      else
      begin
         quiet_ff <= nxt_quiet;
         config_clock_q_ff <= config_clock;
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   oe_sel_a: assert property (select_n[*6] |-> !data_oe)
      else $error("data driven while deselected");
   oe_clr_a: assert property (clr[*6] |-> !data_oe && !read_done)
      else $error("clear level did not float data");
   sby_hi_a: assert property (select_n[*6] |-> standby)
      else $error("no standby while deselected");
   sby_lo_a: assert property ((!select_n)[*6] |-> !standby)
      else $error("standby while selected");
   cas_off_a: assert property ((select_n || clr)[*6] |-> cascade_enable_out_n)
      else $error("cascade low while inactive");
   cas_on_a: assert property ((read_done && !select_n && !clr)[*6] |-> !cascade_enable_out_n)
      else $error("cascade not following select");
   cas_rel_a: assert property (!cascade_enable_out_n |-> !data_oe)
      else $error("data driven after hand over");
   no_wrap_a: assert property (rom_rd_en |-> rom_addr < LAST_ADDRESS_LIMIT)
      else $error("fetch beyond last address");
   dat_hold_a: assert property (quiet_ff == 3'h7 && data_oe && $past(data_oe, 4) |-> $stable(data_out))
      else $error("data moved without a clock");
   cover property ($fell(cascade_enable_out_n));
   cover property ($rose(read_done));
   cover property ($rose(data_oe));
endmodule
bind scp_reader scp_reader_props
  #(.LAST_ADDRESS_LIMIT(LAST_ADDRESS_LIMIT), .ADDR_W(ADDR_W), .GATE_CLEAR_HIGH(GATE_CLEAR_HIGH))
  props_u (.clk(clk), .reset_n(reset_n), .config_clock(config_clock), .select_n(select_n),
           .clear_gate(clear_gate), .data_out(data_out), .data_oe(data_oe),
           .cascade_enable_out_n(cascade_enable_out_n), .standby(standby),
           .rom_rd_en(rom_rd_en), .rom_addr(rom_addr), .rom_bit(rom_bit), .read_done(read_done));
`default_nettype wire

//--- verification/scp_loader.sv
/*
 loader model: makes bursts of config_clock and samples the data pin.
 assumes the data line is pulled up while released.
*/
`timescale 1ns/10ps
`default_nettype none
module scp_loader
  (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [3:0]  n_pulses,
   input  wire logic        din,
   output var  logic        config_clock,
   output var  logic        busy,
   output var  logic [15:0] got
  );
   logic [3:0] left;
   logic [2:0] ph;
   initial
   begin
      config_clock = 1'b0;
      left = 4'h0;
      ph = 3'h0;
      got = 16'h0000;
   end
   assign busy = (left != 4'h0);
   always @(posedge clk)
   begin
      if (go)
      begin
         left <= n_pulses;
         ph <= 3'h0;
      end
      else if (busy)
      begin
         ph <= ph + 3'h1;
         if (ph == 3'h3)
         begin
            config_clock <= 1'b1;
            got <= {din, got[15:1]};
         end
         if (ph == 3'h7)
         begin
            config_clock <= 1'b0;
            left <= left - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/scp_reader_test.sv
/*
 testbench for the serial configuration memory reader.
 assumes the loader model and a pattern memory on the fetch port.
*/
`timescale 1ns/10ps
`default_nettype none
module scp_reader_test;
   logic        clk = 1'b0;
   logic        reset_n, select_n, clear_gate, go, din, rom_bit;
   logic        config_clock, busy, data_out, data_oe, cascade_enable_out_n;
   logic        standby, rom_rd_en, read_done;
   logic [3:0]  n_pulses, rom_addr;
   logic [7:0]  pat;
   logic [15:0] got;
   int          mismatches = 0;
   int          n_tests = 0;
   always #4 clk = ~clk;
   assign din = data_oe ? data_out : 1'b1;
   assign rom_bit = rom_addr[3] ? 1'b0 : pat[rom_addr[2:0]];
   scp_reader #(.LAST_ADDRESS_LIMIT(8), .ADDR_W(4), .GATE_CLEAR_HIGH(1'b1)) dut_u
     (.clk(clk), .reset_n(reset_n), .config_clock(config_clock), .select_n(select_n),
      .clear_gate(clear_gate), .data_out(data_out), .data_oe(data_oe),
      .cascade_enable_out_n(cascade_enable_out_n), .standby(standby),
      .rom_rd_en(rom_rd_en), .rom_addr(rom_addr), .rom_bit(rom_bit), .read_done(read_done));
   scp_loader ld_u
     (.clk(clk), .go(go), .n_pulses(n_pulses), .din(din), .config_clock(config_clock),
      .busy(busy), .got(got));
   task automatic chk(input logic [15:0] exp, input logic [15:0] act);
      n_tests++;
      if (act !== exp)
      begin
         mismatches++;
         $display("Error at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic e(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic drv(input logic s, input logic c);
      @(posedge clk);
      select_n <= s;
      clear_gate <= c;
      e(8);
      @(negedge clk);
   endtask
   task automatic run(input logic [3:0] n);
      int i = 0;
      @(posedge clk);
      n_pulses <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy && i < 300)
      begin
         @(posedge clk);
         i++;
      end
      e(6);
      @(negedge clk);
   endtask
   task automatic t_reset;
      @(negedge clk);
      chk(16'h0000, data_oe);
      chk(16'h0001, cascade_enable_out_n);
      chk(16'h0001, standby);
      chk(16'h0000, read_done);
      $display("test reset done");
   endtask
   task automatic t_full;
      pat = 8'hb4;
      drv(1'b0, 1'b0);
      chk(16'h0000, standby);
      run(4'h8);
      chk({8'h00, pat}, {8'h00, got[15:8]});
      chk(16'h0001, read_done);
      chk(16'h0000, cascade_enable_out_n);
      chk(16'h0000, data_oe);
      run(4'h3);
      chk({8'h00, 3'b111, pat[7:3]}, {8'h00, got[15:8]});
      chk(16'h0000, cascade_enable_out_n);
      drv(1'b1, 1'b0);
      chk(16'h0001, cascade_enable_out_n);
      chk(16'h0001, standby);
      drv(1'b0, 1'b0);
      chk(16'h0000, cascade_enable_out_n);
      drv(1'b0, 1'b1);
      chk(16'h0001, cascade_enable_out_n);
      chk(16'h0000, read_done);
      $display("test full read done");
   endtask
   task automatic t_abort;
      pat = 8'h4d;
      drv(1'b0, 1'b0);
      run(4'h3);
      drv(1'b0, 1'b1);
      chk(16'h0000, data_oe);
      run(4'h2);
      drv(1'b0, 1'b0);
      run(4'h8);
      chk({8'h00, pat}, {8'h00, got[15:8]});
      $display("test abort done");
   endtask
   task automatic t_standby;
      drv(1'b0, 1'b1);
      pat = 8'h96;
      drv(1'b0, 1'b0);
      run(4'h3);
      drv(1'b1, 1'b0);
      chk(16'h0000, data_oe);
      run(4'h2);
      drv(1'b0, 1'b0);
      run(4'h5);
      chk({6'h00, pat[7:3], 2'b11, pat[2:0]}, {6'h00, got[15:6]});
      $display("test standby done");
   endtask
   task automatic close_out;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      reset_n = 1'b0;
      select_n = 1'b1;
      clear_gate = 1'b1;
      go = 1'b0;
      n_pulses = 4'h0;
      pat = 8'h00;
      e(8);
      reset_n <= 1'b1;
      e(4);
      t_reset;
      t_full;
      t_abort;
      t_standby;
      close_out;
   end
   initial
   begin
      e(20000);
      mismatches++;
      close_out;
   end
endmodule
`default_nettype wire
